/* File: hdl/lcie_pkg.sv */
// Package: register map, field positions, reset values and carriers
//
// Contract
// - Control bit 1 drives transfer start output
// - Control bit 0 drives program request output
// - Control bits 31:2 read zero, ignore writes
// - Uncorrectable bit 11 on receive buffer overflow
// - Bits 9,8,3 on internal bus parity errors
// - Bit 7 on outgoing packet parity, drop packet
// - Bit 6 on application uncorrectable error report
// - Bit 5 on load error rise in mode
// - Bit 4 link layer parity, bit 2 buffer
// - Bit 1 on retry buffer uncorrectable ECC
// - Bit 0 receive ECC; sticky write-one-clear
// - Forward uncorrectable error only when unmasked
// - Uncorrectable mask sticky, documented reset values
// - Correctable bit 5 on load error in mode
// - Correctable bits 1,0 on ECC errors
// - Correctable status reset zero, write-one-clear
// - Correctable mask bit 6 gates application errors
// - Correctable mask sticky; unmasked errors forwarded
// - Link load mode routes packets to config space
// - Load error input reflects control block signal
package lcie_pkg;

  // Register indexes within the bank (local choice)
  localparam logic [2:0] ADDR_PROG_CTRL = 3'h0;
  localparam logic [2:0] ADDR_UNC_STAT  = 3'h1;
  localparam logic [2:0] ADDR_UNC_MASK  = 3'h2;
  localparam logic [2:0] ADDR_COR_STAT  = 3'h3;
  localparam logic [2:0] ADDR_COR_MASK  = 3'h4;

  // Programming control field positions
  localparam int PC_REQ_BIT   = 0;
  localparam int PC_START_BIT = 1;
  localparam logic [31:0] PC_WMASK = 32'h0000_0003;

  // Uncorrectable status field positions
  localparam int UNC_RXECC  = 0;
  localparam int UNC_RTECC  = 1;
  localparam int UNC_RXBPAR = 2;
  localparam int UNC_RXCPAR = 3;
  localparam int UNC_DLPAR  = 4;
  localparam int UNC_LOAD   = 5;
  localparam int UNC_APP    = 6;
  localparam int UNC_TLPPAR = 7;
  localparam int UNC_TXCPAR = 8;
  localparam int UNC_CTXPAR = 9;
  localparam int UNC_OVFL   = 11;

  // Correctable status and mask field positions
  localparam int COR_RXECC = 0;
  localparam int COR_RTECC = 1;
  localparam int COR_LOAD  = 5;
  localparam int COR_APP   = 6;

  // Implemented bits and reset values
  localparam logic [31:0] UNC_STAT_WMASK = 32'h0000_0BFF;
  localparam logic [31:0] UNC_MASK_WMASK = 32'h0000_0BBF;
  localparam logic [31:0] UNC_MASK_RST   = 32'h0000_0B9F;
  localparam logic [31:0] COR_STAT_WMASK = 32'h0000_0023;
  localparam logic [31:0] COR_MASK_WMASK = 32'h0000_0063;
  localparam logic [31:0] COR_MASK_RST   = 32'h0000_0043;
  localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;

  // Internal error event strobes from the link core
  typedef struct packed {
    logic rx_overflow;      // Receive buffer overflow
    logic cfg_tx_parity;    // Config to transmit bus parity
    logic tx_cfg_parity;    // Transmit to config bus parity
    logic tlp_parity;       // Outgoing packet parity
    logic app_uncorr;       // Application uncorrectable report
    logic dll_parity;       // Transmit data link parity
    logic rx_cfg_parity;    // Receive to config bus parity
    logic rxbuf_parity;     // Receive buffer input parity
    logic retry_ecc_unc;    // Retry buffer uncorrectable ECC
    logic rxbuf_ecc_unc;    // Receive buffer uncorrectable ECC
    logic retry_ecc_cor;    // Retry buffer correctable ECC
    logic rxbuf_ecc_cor;    // Receive buffer correctable ECC
    logic app_corr;         // Application corrected error report
  } lcie_err_t;

  // Configuration register access request
  typedef struct packed {
    logic        wr;        // Write strobe
    logic        rd;        // Read strobe
    logic [2:0]  addr;      // Register index
    logic [31:0] wdata;     // Write data
  } lcie_cfg_req_t;

endpackage

/* File: hdl/lcie_regs.sv */
// Module: programming control and internal error register bank
`timescale 1ns/10ps
`default_nettype none

module lcie_regs
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire lcie_pkg::lcie_cfg_req_t cfg_req_i,
  input  wire lcie_pkg::lcie_err_t     err_i,
  input  wire logic                    link_load_mode_i,
  input  wire logic                    load_error_input_i,
  input  wire logic                    tlp_valid_i,
  output logic [31:0]                  rdata_o,
  output logic                         rvalid_o,
  output logic                         program_request_o,
  output logic                         transfer_start_flag_o,
  output logic                         tlp_send_o,
  output logic                         tlp_to_config_o,
  output logic                         tlp_to_app_o,
  output logic                         unc_internal_o,
  output logic                         cor_internal_o
);

  logic [31:0] pc_reg;          // Programming control
  logic [31:0] us_reg;          // Uncorrectable status
  logic [31:0] um_reg;          // Uncorrectable mask
  logic [31:0] cs_reg;          // Correctable status
  logic [31:0] cm_reg;          // Correctable mask
  logic        lerr_reg;        // Previous load error level
  logic [31:0] us_next;         // Uncorrectable status next
  logic [31:0] cs_next;         // Correctable status next
  logic [31:0] us_set;          // Uncorrectable events this cycle
  logic [31:0] cs_set;          // Correctable events this cycle
  logic        load_rise;       // Load error rising in mode
  logic        load_lvl;        // Load error level in mode

  // Write strobe to one register index
  function automatic logic wr_hit(input lcie_pkg::lcie_cfg_req_t r,
                                  input logic [2:0] a);
    wr_hit = r.wr && (r.addr == a);
  endfunction

  // Masked write keeping only implemented bits
  function automatic logic [31:0] wfield(input logic [31:0] d,
                                         input logic [31:0] m);
    wfield = d & m;
  endfunction

  // Load error qualification by mode
  assign load_rise = link_load_mode_i && load_error_input_i
                     && !lerr_reg;
  assign load_lvl  = link_load_mode_i && load_error_input_i;

  // Uncorrectable event vector
  always_comb
  begin
    us_set = lcie_pkg::ZERO_WORD;
    us_set[lcie_pkg::UNC_OVFL]   = err_i.rx_overflow;
    us_set[lcie_pkg::UNC_CTXPAR] = err_i.cfg_tx_parity;
    us_set[lcie_pkg::UNC_TXCPAR] = err_i.tx_cfg_parity;
    us_set[lcie_pkg::UNC_RXCPAR] = err_i.rx_cfg_parity;
    us_set[lcie_pkg::UNC_TLPPAR] = err_i.tlp_parity;
    us_set[lcie_pkg::UNC_APP]    = err_i.app_uncorr;
    us_set[lcie_pkg::UNC_LOAD]   = load_rise;
    us_set[lcie_pkg::UNC_DLPAR]  = err_i.dll_parity;
    us_set[lcie_pkg::UNC_RXBPAR] = err_i.rxbuf_parity;
    us_set[lcie_pkg::UNC_RTECC]  = err_i.retry_ecc_unc;
    us_set[lcie_pkg::UNC_RXECC]  = err_i.rxbuf_ecc_unc;
  end

  // Correctable event vector
  always_comb
  begin
    cs_set = lcie_pkg::ZERO_WORD;
    cs_set[lcie_pkg::COR_LOAD]  = load_lvl;
    cs_set[lcie_pkg::COR_RTECC] = err_i.retry_ecc_cor;
    cs_set[lcie_pkg::COR_RXECC] = err_i.rxbuf_ecc_cor;
  end

  // Sticky status: new events win over a write-one clear
  always_comb
  begin
    us_next = us_reg;
    cs_next = cs_reg;
    if (wr_hit(cfg_req_i, lcie_pkg::ADDR_UNC_STAT))
    begin
      us_next = us_reg & ~cfg_req_i.wdata;
    end
    if (wr_hit(cfg_req_i, lcie_pkg::ADDR_COR_STAT))
    begin
      cs_next = cs_reg & ~cfg_req_i.wdata;
    end
    // Events record independent of mask bits
    us_next = (us_next | us_set) & lcie_pkg::UNC_STAT_WMASK;
    cs_next = (cs_next | cs_set) & lcie_pkg::COR_STAT_WMASK;
  end

  // Programming control register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pc_reg <= lcie_pkg::ZERO_WORD;
    end
    else if (wr_hit(cfg_req_i, lcie_pkg::ADDR_PROG_CTRL))
    begin
      pc_reg <= wfield(cfg_req_i.wdata, lcie_pkg::PC_WMASK);
    end
  end

  // Status registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      us_reg <= lcie_pkg::ZERO_WORD;
      cs_reg <= lcie_pkg::ZERO_WORD;
    end
    else
    begin
      us_reg <= us_next;
      cs_reg <= cs_next;
    end
  end

  // Mask registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      um_reg <= lcie_pkg::UNC_MASK_RST;
      cm_reg <= lcie_pkg::COR_MASK_RST;
    end
    else
    begin
      if (wr_hit(cfg_req_i, lcie_pkg::ADDR_UNC_MASK))
      begin
        um_reg <= wfield(cfg_req_i.wdata,
                         lcie_pkg::UNC_MASK_WMASK);
      end
      if (wr_hit(cfg_req_i, lcie_pkg::ADDR_COR_MASK))
      begin
        cm_reg <= wfield(cfg_req_i.wdata,
                         lcie_pkg::COR_MASK_WMASK);
      end
    end
  end

  // Load error edge tracking
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lerr_reg <= 1'b0;
    end
    else
    begin
      lerr_reg <= load_error_input_i;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_o  <= lcie_pkg::ZERO_WORD;
      rvalid_o <= 1'b0;
    end
    else
    begin
      rvalid_o <= cfg_req_i.rd;
      if (cfg_req_i.rd)
      begin
        unique case (cfg_req_i.addr)
          lcie_pkg::ADDR_PROG_CTRL: rdata_o <= pc_reg;
          lcie_pkg::ADDR_UNC_STAT:  rdata_o <= us_reg;
          lcie_pkg::ADDR_UNC_MASK:  rdata_o <= um_reg;
          lcie_pkg::ADDR_COR_STAT:  rdata_o <= cs_reg;
          lcie_pkg::ADDR_COR_MASK:  rdata_o <= cm_reg;
          default:                  rdata_o <= lcie_pkg::ZERO_WORD;
        endcase
      end
    end
  end

  // Control outputs follow the programming control register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      program_request_o     <= 1'b0;
      transfer_start_flag_o <= 1'b0;
    end
    else
    begin
      program_request_o     <= pc_next_bit(lcie_pkg::PC_REQ_BIT);
      transfer_start_flag_o <= pc_next_bit(lcie_pkg::PC_START_BIT);
    end
  end

  // Next value of one control bit
  function automatic logic pc_next_bit(input int b);
    if (wr_hit(cfg_req_i, lcie_pkg::ADDR_PROG_CTRL))
      pc_next_bit = cfg_req_i.wdata[b];
    else
      pc_next_bit = pc_reg[b];
  endfunction

  // Packet routing and outgoing parity drop
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tlp_send_o      <= 1'b0;
      tlp_to_config_o <= 1'b0;
      tlp_to_app_o    <= 1'b0;
    end
    else
    begin
      tlp_send_o      <= tlp_valid_i && !err_i.tlp_parity;
      tlp_to_config_o <= tlp_valid_i && link_load_mode_i;
      tlp_to_app_o    <= tlp_valid_i && !link_load_mode_i;
    end
  end

  // Forward unmasked events as internal errors
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      unc_internal_o <= 1'b0;
      cor_internal_o <= 1'b0;
    end
    else
    begin
      unc_internal_o <= |(us_set & ~um_reg);
      cor_internal_o <= |(cs_set & ~cm_reg) ||
                        (err_i.app_corr &&
                         !cm_reg[lcie_pkg::COR_APP]);
    end
  end

  // Checks: control register and the outputs it drives
  a_start_follows: assert property (@(posedge clk_i)
    disable iff (rst_i)
    wr_hit(cfg_req_i, lcie_pkg::ADDR_PROG_CTRL) |=>
    transfer_start_flag_o == $past(cfg_req_i.wdata[lcie_pkg::PC_START_BIT]))
    else $error("transfer start not following write");
  a_req_follows: assert property (@(posedge clk_i)
    disable iff (rst_i)
    program_request_o == pc_reg[lcie_pkg::PC_REQ_BIT])
    else $error("program request differs from register");
  a_req_write: assert property (@(posedge clk_i)
    disable iff (rst_i)
    wr_hit(cfg_req_i, lcie_pkg::ADDR_PROG_CTRL) |=>
    program_request_o == $past(cfg_req_i.wdata[lcie_pkg::PC_REQ_BIT]))
    else $error("program request not following write");
  a_ctrl_reserved: assert property (@(posedge clk_i)
    disable iff (rst_i)
    pc_reg[31:2] == 30'h0)
    else $error("control reserved bits set");

  // Checks: uncorrectable status, masks and forwarding
  a_overflow_sets: assert property (@(posedge clk_i)
    disable iff (rst_i)
    err_i.rx_overflow |=> us_reg[lcie_pkg::UNC_OVFL])
    else $error("overflow not recorded");
  a_parity_sets: assert property (@(posedge clk_i)
    disable iff (rst_i)
    err_i.cfg_tx_parity |=> us_reg[lcie_pkg::UNC_CTXPAR])
    else $error("bus parity error not recorded");
  a_tlp_dropped: assert property (@(posedge clk_i)
    disable iff (rst_i)
    err_i.tlp_parity |=> !tlp_send_o && us_reg[lcie_pkg::UNC_TLPPAR])
    else $error("bad packet sent or unrecorded");
  a_app_unc_sets: assert property (@(posedge clk_i)
    disable iff (rst_i)
    err_i.app_uncorr |=> us_reg[lcie_pkg::UNC_APP])
    else $error("application error not recorded");
  a_load_rise: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (link_load_mode_i && $rose(load_error_input_i)) |=>
    us_reg[lcie_pkg::UNC_LOAD])
    else $error("load error rise not recorded");
  a_unc_reserved: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (us_reg & ~lcie_pkg::UNC_STAT_WMASK) == 32'h0)
    else $error("uncorrectable reserved bits set");
  a_unc_clear: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (wr_hit(cfg_req_i, lcie_pkg::ADDR_UNC_STAT) &&
     us_set == lcie_pkg::ZERO_WORD) |=>
    (us_reg & $past(cfg_req_i.wdata)) == lcie_pkg::ZERO_WORD)
    else $error("write one did not clear status");
  a_unc_forward: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (err_i.rxbuf_ecc_unc && !um_reg[lcie_pkg::UNC_RXECC]) |=>
    unc_internal_o)
    else $error("unmasked error not forwarded");
  a_masked_quiet: assert property (@(posedge clk_i)
    disable iff (rst_i)
    ((us_set & ~um_reg) == lcie_pkg::ZERO_WORD) |=> !unc_internal_o)
    else $error("masked error forwarded");
  a_mask_reserved: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (um_reg & ~lcie_pkg::UNC_MASK_WMASK) == lcie_pkg::ZERO_WORD)
    else $error("uncorrectable mask reserved bits set");

  // Checks: correctable status, forwarding and packet routing
  a_cor_load: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (link_load_mode_i && load_error_input_i) |=>
    cs_reg[lcie_pkg::COR_LOAD])
    else $error("load error level not recorded");
  a_cor_ecc: assert property (@(posedge clk_i)
    disable iff (rst_i)
    err_i.rxbuf_ecc_cor |=> cs_reg[lcie_pkg::COR_RXECC])
    else $error("correctable ECC error not recorded");
  a_cor_reserved: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (cs_reg & ~lcie_pkg::COR_STAT_WMASK) == lcie_pkg::ZERO_WORD)
    else $error("correctable reserved bits set");
  a_cor_app_fwd: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (err_i.app_corr && !cm_reg[lcie_pkg::COR_APP]) |=>
    cor_internal_o)
    else $error("corrected application error not forwarded");
  a_masked_records: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (err_i.retry_ecc_cor && cm_reg[lcie_pkg::COR_RTECC]) |=>
    cs_reg[lcie_pkg::COR_RTECC])
    else $error("masked event not recorded");
  a_route_config: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (tlp_valid_i && link_load_mode_i) |=> tlp_to_config_o && !tlp_to_app_o)
    else $error("packet not routed to config");
  a_route_app: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (tlp_valid_i && !link_load_mode_i) |=> tlp_to_app_o && !tlp_to_config_o)
    else $error("packet not routed to application");

  // Main scenarios
  c_clear_write: cover property (@(posedge clk_i)
    us_reg != 32'h0 ##1 wr_hit(cfg_req_i, lcie_pkg::ADDR_UNC_STAT));
  c_load_error: cover property (@(posedge clk_i)
    link_load_mode_i && $rose(load_error_input_i));
  c_forward_cor: cover property (@(posedge clk_i) cor_internal_o);
  c_tlp_drop: cover property (@(posedge clk_i)
    tlp_valid_i && err_i.tlp_parity);
  c_masked_event: cover property (@(posedge clk_i)
    err_i.rx_overflow && um_reg[lcie_pkg::UNC_OVFL]);

endmodule

`default_nettype wire

/* File: tb/lcie_ctrl_model.sv */
// Control block model: raises the load error level during a request when a fault is ordered
`timescale 1ns/10ps
`default_nettype none

module lcie_ctrl_model
(
  input  wire logic clk_i,
  input  wire logic program_request_i,
  input  wire logic fail_cmd_i,
  output var  logic load_error_o
);
  // Quiet until the first clock edge
  initial load_error_o = 1'b0;

  // Error level only while programming is requested and a fault is ordered
  always @(posedge clk_i)
  begin
    load_error_o <= program_request_i & fail_cmd_i;
  end
endmodule

`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the register bank
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  logic                    clk_i;
  logic                    rst_i;
  lcie_pkg::lcie_cfg_req_t cfg_req;
  lcie_pkg::lcie_err_t     err;
  logic                    mode, load_err, fail_cmd, tlp_valid;
  logic [31:0]             rdata;
  logic                    rvalid, prog_req, start, tlp_send;
  logic                    to_cfg, to_app, unc_int, cor_int;
  int                      fail_count, checked, cycles, unc_seen, cor_seen;

  lcie_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .cfg_req_i(cfg_req),
    .err_i(err), .link_load_mode_i(mode), .load_error_input_i(load_err),
    .tlp_valid_i(tlp_valid), .rdata_o(rdata), .rvalid_o(rvalid),
    .program_request_o(prog_req), .transfer_start_flag_o(start),
    .tlp_send_o(tlp_send), .tlp_to_config_o(to_cfg),
    .tlp_to_app_o(to_app), .unc_internal_o(unc_int),
    .cor_internal_o(cor_int));

  lcie_ctrl_model ctrl_u (.clk_i(clk_i), .program_request_i(prog_req),
    .fail_cmd_i(fail_cmd), .load_error_o(load_err));

  // 200 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Cycle ceiling and counters of cycles with a forwarded error high
  always @(posedge clk_i)
  begin
    cycles++;
    if (unc_int === 1'b1)
      unc_seen++;
    if (cor_int === 1'b1)
      cor_seen++;
    if (cycles == 5000)
    begin
      fail_count++;
      close_out();
    end
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  // Register write; every driver starts just after a rising edge
  task automatic reg_wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk_i);
    #1 cfg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    #1 cfg_req <= '0;
  endtask

  // Register read, answer seen one cycle after the strobe
  task automatic reg_rd(input logic [2:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    #1 cfg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk_i);
    #1 cfg_req <= '0;
    chk_bit(rvalid, 1'b1);
    chk_word(rdata, exp);
  endtask

  // One-cycle error strobes, optionally with a packet present
  task automatic pulse_err(input logic [12:0] v, input logic t);
    @(posedge clk_i);
    #1 err <= lcie_pkg::lcie_err_t'(v);
    tlp_valid <= t;
    @(posedge clk_i);
    #1 err <= '0;
    tlp_valid <= 1'b0;
  endtask

  task automatic t_reset();
    logic [31:0] exp [6];
    exp = '{32'h0, 32'h0, 32'h0B9F, 32'h0, 32'h0043, 32'h0};
    for (int i = 0; i < 6; i++)
      reg_rd(3'(i), exp[i]);
    $display("test reset values done");
  endtask

  task automatic t_ctrl();
    logic [31:0] v [4];
    v = '{32'hFFFF_FFFF, 32'h2, 32'h1, 32'h0};
    for (int i = 0; i < 4; i++)
    begin
      reg_wr(lcie_pkg::ADDR_PROG_CTRL, v[i]);
      reg_rd(lcie_pkg::ADDR_PROG_CTRL, v[i] & 32'h3);
      chk_bit(prog_req, v[i][0]);
      chk_bit(start, v[i][1]);
    end
    $display("test control done");
  endtask

  task automatic t_unc();
    int         ub [10];
    logic [2:0] sa;
    ub = '{11, 9, 8, 7, 6, 4, 3, 2, 1, 0};
    sa = lcie_pkg::ADDR_UNC_STAT;
    reg_wr(lcie_pkg::ADDR_UNC_MASK, 32'h0);
    for (int i = 0; i < 10; i++)
    begin
      pulse_err(13'h1000 >> i, 1'b0);
      chk_bit(unc_int, 1'b1);
      reg_rd(sa, 32'h1 << ub[i]);
      reg_wr(lcie_pkg::ADDR_UNC_STAT, 32'h1 << ub[i]);
    end
    reg_wr(lcie_pkg::ADDR_UNC_MASK, 32'hFFFF_FFFF);
    reg_rd(lcie_pkg::ADDR_UNC_MASK, 32'h0BBF);
    pulse_err(13'h1000, 1'b0);
    chk_bit(unc_int, 1'b0);
    reg_wr(lcie_pkg::ADDR_UNC_STAT, 32'h0);
    reg_rd(lcie_pkg::ADDR_UNC_STAT, 32'h0800);
    reg_wr(lcie_pkg::ADDR_UNC_STAT, 32'hFFFF_FFFF);
    reg_rd(lcie_pkg::ADDR_UNC_STAT, 32'h0);
    reg_wr(lcie_pkg::ADDR_UNC_MASK, 32'h0B9F);
    $display("test uncorrectable done");
  endtask

  task automatic t_load();
    unc_seen = 0;
    cor_seen = 0;
    mode <= 1'b1;
    fail_cmd <= 1'b1;
    reg_wr(lcie_pkg::ADDR_PROG_CTRL, 32'h1);
    repeat (6) @(posedge clk_i);
    reg_rd(lcie_pkg::ADDR_UNC_STAT, 32'h20);
    reg_rd(lcie_pkg::ADDR_COR_STAT, 32'h20);
    reg_wr(lcie_pkg::ADDR_UNC_STAT, 32'h20);
    reg_wr(lcie_pkg::ADDR_COR_STAT, 32'h20);
    reg_rd(lcie_pkg::ADDR_UNC_STAT, 32'h0);
    reg_rd(lcie_pkg::ADDR_COR_STAT, 32'h20);
    chk_word(32'(unc_seen), 32'h1);
    chk_bit(cor_seen > 0, 1'b1);
    mode <= 1'b0;
    reg_wr(lcie_pkg::ADDR_PROG_CTRL, 32'h0);
    reg_wr(lcie_pkg::ADDR_PROG_CTRL, 32'h1);
    reg_wr(lcie_pkg::ADDR_COR_STAT, 32'h20);
    repeat (4) @(posedge clk_i);
    reg_rd(lcie_pkg::ADDR_UNC_STAT, 32'h0);
    reg_rd(lcie_pkg::ADDR_COR_STAT, 32'h0);
    fail_cmd <= 1'b0;
    reg_wr(lcie_pkg::ADDR_PROG_CTRL, 32'h0);
    $display("test load error done");
  endtask

  task automatic t_cor();
    pulse_err(13'h4, 1'b0);
    chk_bit(cor_int, 1'b0);
    pulse_err(13'h2, 1'b0);
    reg_rd(lcie_pkg::ADDR_COR_STAT, 32'h3);
    reg_wr(lcie_pkg::ADDR_COR_STAT, 32'hFFFF_FFFF);
    reg_rd(lcie_pkg::ADDR_COR_STAT, 32'h0);
    reg_wr(lcie_pkg::ADDR_COR_MASK, 32'h0);
    pulse_err(13'h4, 1'b0);
    chk_bit(cor_int, 1'b1);
    pulse_err(13'h1, 1'b0);
    chk_bit(cor_int, 1'b1);
    reg_wr(lcie_pkg::ADDR_COR_MASK, 32'hFFFF_FFFF);
    reg_rd(lcie_pkg::ADDR_COR_MASK, 32'h63);
    pulse_err(13'h1, 1'b0);
    chk_bit(cor_int, 1'b0);
    reg_rd(lcie_pkg::ADDR_COR_STAT, 32'h2);
    $display("test correctable done");
  endtask

  task automatic t_tlp();
    for (int m = 0; m < 2; m++)
    begin
      mode <= m[0];
      pulse_err(13'h0, 1'b1);
      chk_bit(tlp_send, 1'b1);
      chk_bit(to_cfg, m[0]);
      chk_bit(to_app, ~m[0]);
    end
    mode <= 1'b0;
    pulse_err(13'h200, 1'b1);
    chk_bit(tlp_send, 1'b0);
    reg_rd(lcie_pkg::ADDR_UNC_STAT, 32'h80);
    $display("test packet done");
  endtask

  // Verdict; status registers are only observed, never steer the run
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    rst_i = 1'b1;
    cfg_req = '0;
    err = '0;
    mode = 1'b0;
    fail_cmd = 1'b0;
    tlp_valid = 1'b0;
    repeat (5) @(posedge clk_i);
    #1 rst_i = 1'b0;
    t_reset();
    t_ctrl();
    t_unc();
    t_load();
    t_cor();
    t_tlp();
    close_out();
  end
endmodule

`default_nettype wire
